// >>> tb_top.sv
// testbench: register map, interrupt and comparator alarm, polarity
// assumes tla_alarm, tla_host_model and the bound checker
`timescale 1ns/10ps
module tb_top;
  localparam logic [15:0] HY = {1'b0, tla_pkg::TLA_HYST_RST, 7'h00};
  localparam logic [15:0] UP = tla_pkg::TLA_UPPER_RST;
  localparam logic [15:0] LO = tla_pkg::TLA_LOWER_RST;
  localparam logic [7:0] CF = tla_pkg::TLA_ADDR_CONFIG;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tla_pkg::tla_req_s req;
  tla_pkg::tla_sample_s sample = '0;
  logic [7:0] rdata;
  logic rvalid, convert_run, alarm_out, alarm_oe, shutdown;
  int mismatches = 0;
  int n_checks = 0;
  tla_alarm dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .sample(sample),
    .convert_run(convert_run), .alarm_out(alarm_out), .alarm_oe(alarm_oe), .shutdown(shutdown));
  tla_host_model host (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req));
  initial forever #2 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk({8'h00, d}, {8'h00, e});
    chk({15'h0, v}, 16'h0001);
  endtask : rchk
  // one converter strobe, then the alarm pin a settled edge later
  task automatic smp(input logic [15:0] t, input logic exp_oe);
    @(posedge mclk) sample <= '{1'b1, t};
    @(posedge mclk) sample <= '{1'b0, ~t};
    #1 chk({15'h0, alarm_oe}, {15'h0, exp_oe});
  endtask : smp
  task automatic t_map();
    logic [55:0] e;
    e = {tla_pkg::TLA_CONFIG_RST, UP, LO, tla_pkg::TLA_CRIT_RST};
    for (int i = 0; i < 7; i++) rchk(CF + 8'(i), e[55 - 8 * i -: 8]);
    host.wr(tla_pkg::TLA_ADDR_IDENT, 8'h00);
    rchk(tla_pkg::TLA_ADDR_IDENT, tla_pkg::TLA_IDENT_VAL);
    rchk(8'h0c, 8'h00);
  endtask : t_map
  task automatic t_int();
    smp(UP + 16'h1, 1'b1);
    rchk(CF, 8'h00);
    chk({15'h0, alarm_oe}, 16'h0000);
    smp(UP, 1'b0);
    smp(LO - 16'h1, 1'b1);
    host.wr(CF, 8'h60);
    chk({15'h0, shutdown}, 16'h0001);
    @(posedge mclk);
    #1 chk({15'h0, alarm_oe}, 16'h0000);
    chk({15'h0, alarm_out}, 16'h0000);
    chk({15'h0, convert_run}, 16'h0000);
    host.wr(CF, 8'h00);
    chk({15'h0, convert_run}, 16'h0001);
  endtask : t_int
  task automatic t_cmp();
    logic [15:0] d;
    host.wr(CF, 8'h10);
    smp(UP + 16'h1, 1'b1);
    rchk(CF, 8'h10);
    chk({15'h0, alarm_oe}, 16'h0001);
    smp(UP - HY, 1'b1);
    host.wr(CF, 8'h70);
    chk({15'h0, alarm_oe}, 16'h0001);
    host.wr(CF, 8'h10);
    smp(UP - HY - 16'h1, 1'b0);
    smp(LO - 16'h1, 1'b1);
    smp(LO + HY, 1'b1);
    smp(LO + HY + 16'h1, 1'b0);
    host.wr(CF, 8'h18);
    chk({15'h0, alarm_oe}, 16'h0001);
    smp(16'hff00, 1'b0);
    host.rd16(tla_pkg::TLA_ADDR_TEMP_MSB, d);
    chk(d, 16'hff00);
  endtask : t_cmp
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_map();
    t_int();
    t_cmp();
    stop_test();
  end
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule : tb_top

// >>> tla_alarm.sv
// temperature limit alarm: registers, limit compare, alarm pin
// assumes a serial slave engine on mclk presents byte requests and
// a converter delivers one-cycle sample strobes on mclk
//
// How it works
// - comparator or interrupt; interrupt after reset
// - alarm when above upper or below lower
// - comparator releases below upper minus hysteresis, above lower plus hysteresis
// - comparator keeps alarm through shutdown
// - interrupt mode: any read clears alarm, except in a cycle where a violating sample arrives
// - interrupt re-arms only on new violation
// - interrupt mode: shutdown clears alarm
// - alarm polarity selectable in every mode
// - continuous conversion from reset, no command
// - fixed identity at location 0x0b
// - configuration and limits at fixed locations
// - temperature readable as 16-bit value
// - two-byte read advances pointer msb to lsb
`timescale 1ns/10ps
module tla_alarm (
  input wire logic mclk,
  input wire logic rst,
  input tla_pkg::tla_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  input tla_pkg::tla_sample_s sample,
  output logic convert_run,
  output logic alarm_out,
  output logic alarm_oe,
  output logic shutdown
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] config_reg, config_next;
  logic [15:0] upper_reg, upper_next;
  logic [15:0] lower_reg, lower_next;
  logic [15:0] crit_reg, crit_next;
  logic [7:0] hyst_reg, hyst_next;
  logic [15:0] temp_reg;
  logic [7:0] temp_lsb_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg;
  logic [1:0] flags_reg;

  wire wr_en = req.wr;
  wire rd_en = req.rd;
  wire [7:0] wa = req.addr;
  wire [7:0] wd = req.wdata;

  assign config_next = (wr_en && wa == tla_pkg::TLA_ADDR_CONFIG) ? wd : config_reg;
  assign upper_next = {(wr_en && wa == tla_pkg::TLA_ADDR_UPPER_MSB) ? wd : upper_reg[15:8],
                       (wr_en && wa == tla_pkg::TLA_ADDR_UPPER_LSB) ? wd : upper_reg[7:0]};
  assign lower_next = {(wr_en && wa == tla_pkg::TLA_ADDR_LOWER_MSB) ? wd : lower_reg[15:8],
                       (wr_en && wa == tla_pkg::TLA_ADDR_LOWER_LSB) ? wd : lower_reg[7:0]};
  assign crit_next = {(wr_en && wa == tla_pkg::TLA_ADDR_CRIT_MSB) ? wd : crit_reg[15:8],
                      (wr_en && wa == tla_pkg::TLA_ADDR_CRIT_LSB) ? wd : crit_reg[7:0]};
  assign hyst_next = (wr_en && wa == tla_pkg::TLA_ADDR_HYST) ? {4'h0, wd[3:0]} : hyst_reg;

  // msb read snapshots the lsb so a later sample cannot tear the pair
  wire rd_temp_msb = rd_en && wa == tla_pkg::TLA_ADDR_TEMP_MSB;

  always_comb begin
    unique case (wa)
      tla_pkg::TLA_ADDR_TEMP_MSB: rdata_next = temp_reg[15:8];
      tla_pkg::TLA_ADDR_TEMP_LSB: rdata_next = temp_lsb_reg;
      tla_pkg::TLA_ADDR_STATUS: rdata_next = {6'h00, flags_reg};
      tla_pkg::TLA_ADDR_CONFIG: rdata_next = config_reg;
      tla_pkg::TLA_ADDR_UPPER_MSB: rdata_next = upper_reg[15:8];
      tla_pkg::TLA_ADDR_UPPER_LSB: rdata_next = upper_reg[7:0];
      tla_pkg::TLA_ADDR_LOWER_MSB: rdata_next = lower_reg[15:8];
      tla_pkg::TLA_ADDR_LOWER_LSB: rdata_next = lower_reg[7:0];
      tla_pkg::TLA_ADDR_CRIT_MSB: rdata_next = crit_reg[15:8];
      tla_pkg::TLA_ADDR_CRIT_LSB: rdata_next = crit_reg[7:0];
      tla_pkg::TLA_ADDR_HYST: rdata_next = hyst_reg;
      tla_pkg::TLA_ADDR_IDENT: rdata_next = tla_pkg::TLA_IDENT_VAL;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      config_reg <= tla_pkg::TLA_CONFIG_RST;
      upper_reg <= tla_pkg::TLA_UPPER_RST;
      lower_reg <= tla_pkg::TLA_LOWER_RST;
      crit_reg <= tla_pkg::TLA_CRIT_RST;
      hyst_reg <= tla_pkg::TLA_HYST_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      temp_lsb_reg <= 8'h00;
    end else begin
      config_reg <= config_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      crit_reg <= crit_next;
      hyst_reg <= hyst_next;
      rdata_reg <= rd_en ? rdata_next : rdata_reg;
      rvalid_reg <= rd_en;
      if (rd_temp_msb) begin
        temp_lsb_reg <= temp_reg[7:0];
      end
    end
  end

  assign rdata = rdata_reg;
  assign rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // address pointer: two-byte read steps msb to lsb
  // ----------------------------------------------------------------
  // the serial engine keeps and steps its pointer; this side only
  // snapshots the lsb on an msb read so the pair stays coherent

  // ----------------------------------------------------------------
  // conversion and comparison
  // ----------------------------------------------------------------
  wire mode_cmp = config_reg[tla_pkg::TLA_CFG_MODE_BIT];
  wire pol_high = config_reg[tla_pkg::TLA_CFG_POL_BIT];
  assign shutdown = config_reg[tla_pkg::TLA_CFG_SHDN_LO +: 2] == tla_pkg::TLA_SHDN_CODE;
  assign convert_run = !shutdown;

  wire signed [15:0] t = sample.value;
  wire signed [15:0] hi = upper_reg;
  wire signed [15:0] lo = lower_reg;
  // hysteresis in whole degrees, 1/128 degree lsb
  wire signed [16:0] hmag = {2'b00, hyst_reg[3:0], 7'h00, 4'h0} >>> 4;
  wire signed [16:0] hi_rel = 17'(hi) - hmag;
  wire signed [16:0] lo_rel = 17'(lo) + hmag;
  wire over = t > hi;
  wire under = t < lo;
  wire new_sample = sample.valid && !shutdown;

  logic active_reg, active_next;
  logic cmp_hi_reg, cmp_lo_reg;
  logic [1:0] flags_next;

  always_comb begin
    active_next = active_reg;
    flags_next = flags_reg;
    if (mode_cmp) begin
      if (new_sample) begin
        flags_next = {over || (cmp_hi_reg && 17'(t) >= hi_rel),
                      under || (cmp_lo_reg && 17'(t) <= lo_rel)};
        active_next = flags_next[1] || flags_next[0];
      end
      // shutdown leaves the comparator state alone
    end else begin
      if (rd_en) begin
        active_next = 1'b0;
      end
      if (new_sample && (over || under)) begin
        active_next = 1'b1;
        flags_next = {over, under};
      end
      if (shutdown) begin
        active_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
      flags_reg <= 2'h0;
      cmp_hi_reg <= 1'b0;
      cmp_lo_reg <= 1'b0;
      temp_reg <= 16'h0000;
    end else begin
      active_reg <= active_next;
      flags_reg <= flags_next;
      cmp_hi_reg <= mode_cmp ? flags_next[1] : 1'b0;
      cmp_lo_reg <= mode_cmp ? flags_next[0] : 1'b0;
      if (new_sample) begin
        temp_reg <= sample.value;
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain pin
  // ----------------------------------------------------------------
  // pin low when driven; active-high polarity drives while inactive
  assign alarm_out = 1'b0;
  assign alarm_oe = pol_high ? !active_reg : active_reg;

endmodule : tla_alarm

// >>> tla_alarm_checker.sv
// checker: read port and alarm pin relations of tla_alarm
// assumes bind onto tla_alarm, one mclk domain
`timescale 1ns/10ps
module tla_alarm_checker (
  input logic mclk,
  input logic rst,
  input tla_pkg::tla_req_s req,
  input logic [7:0] rdata,
  input logic rvalid,
  input tla_pkg::tla_sample_s sample,
  input logic convert_run,
  input logic alarm_out,
  input logic alarm_oe,
  input logic shutdown
);
  logic [7:0] cfg_reg;
  wire cfg_wr = req.wr && req.addr == tla_pkg::TLA_ADDR_CONFIG;
  wire act = alarm_oe ^ cfg_reg[3];
  wire intm = !cfg_reg[4] && !req.wr;
  wire cmpm = cfg_reg[4] && !req.wr && !sample.valid;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cfg_reg <= tla_pkg::TLA_CONFIG_RST;
    else if (cfg_wr) cfg_reg <= req.wdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RVALID: assert property (rvalid == $past(req.rd)) else $error("rvalid not one edge after read");
  AST_IDENT: assert property (req.rd && req.addr == tla_pkg::TLA_ADDR_IDENT |=> rdata == tla_pkg::TLA_IDENT_VAL)
    else $error("identity byte wrong");
  AST_RUN: assert property (convert_run == !shutdown) else $error("conversion stopped outside shutdown");
  AST_SHDN: assert property (cfg_wr |=> shutdown == (cfg_reg[6:5] == tla_pkg::TLA_SHDN_CODE))
    else $error("shutdown not taken from config");
  AST_PIN: assert property (alarm_out == 1'b0) else $error("open-drain data not low");
  AST_INT_CLR: assert property (intm && req.rd && !sample.valid |=> !act) else $error("read left alarm set");
  AST_INT_HOLD: assert property (intm && !sample.valid && !act |=> !act) else $error("alarm rose without sample");
  AST_INT_SHDN: assert property (intm && shutdown |=> !act) else $error("alarm set in shutdown");
  AST_CMP_HOLD: assert property (cmpm |=> $stable(alarm_oe)) else $error("comparator alarm moved");
endmodule : tla_alarm_checker
bind tla_alarm tla_alarm_checker chk (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
  .sample(sample), .convert_run(convert_run), .alarm_out(alarm_out), .alarm_oe(alarm_oe), .shutdown(shutdown));

// >>> tla_host_model.sv
// host model: register master issuing byte requests on mclk
// assumes tla_alarm answers a read one edge later with rvalid
`timescale 1ns/10ps
module tla_host_model (
  input logic mclk,
  input logic [7:0] rdata,
  input logic rvalid,
  output tla_pkg::tla_req_s req
);
  initial req = '0;
  // idle lines carry inverted values so a stale address never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~d};
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1 d = rdata;
    v = rvalid;
  endtask : rd
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic v;
    rd(a, d[15:8], v);
    rd(a + 8'h01, d[7:0], v);
  endtask : rd16
endmodule : tla_host_model

// >>> tla_pkg.sv
// temperature limit alarm: shared constants and carrier types
// assumes a register access port driven by a serial slave engine on mclk
package tla_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TLA_ADDR_TEMP_MSB = 8'h00;
  localparam logic [7:0] TLA_ADDR_TEMP_LSB = 8'h01;
  localparam logic [7:0] TLA_ADDR_STATUS = 8'h02;
  localparam logic [7:0] TLA_ADDR_CONFIG = 8'h03;
  localparam logic [7:0] TLA_ADDR_UPPER_MSB = 8'h04;
  localparam logic [7:0] TLA_ADDR_UPPER_LSB = 8'h05;
  localparam logic [7:0] TLA_ADDR_LOWER_MSB = 8'h06;
  localparam logic [7:0] TLA_ADDR_LOWER_LSB = 8'h07;
  localparam logic [7:0] TLA_ADDR_CRIT_MSB = 8'h08;
  localparam logic [7:0] TLA_ADDR_CRIT_LSB = 8'h09;
  localparam logic [7:0] TLA_ADDR_HYST = 8'h0a;
  localparam logic [7:0] TLA_ADDR_IDENT = 8'h0b;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int TLA_CFG_MODE_BIT = 4;
  localparam int TLA_CFG_POL_BIT = 3;
  localparam int TLA_CFG_SHDN_LO = 5;
  localparam logic [1:0] TLA_SHDN_CODE = 2'h3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TLA_CONFIG_RST = 8'h00;
  localparam logic [15:0] TLA_UPPER_RST = 16'h2000;
  localparam logic [15:0] TLA_LOWER_RST = 16'h0500;
  localparam logic [15:0] TLA_CRIT_RST = 16'h4980;
  localparam logic [7:0] TLA_HYST_RST = 8'h05;
  // arbitrary identity value
  localparam logic [7:0] TLA_IDENT_VAL = 8'h5a;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tla_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } tla_sample_s;

endpackage : tla_pkg
